// *** rtl/lbd_defines.svh ***
`ifndef LBD_DEFINES_SVH
`define LBD_DEFINES_SVH

// deserialization factor range and rollover range
`define LBD_FACTOR_MIN 4
`define LBD_FACTOR_MAX 10
`define LBD_ROLL_MIN 1
`define LBD_ROLL_MAX 11
`define LBD_ROLL_DEFAULT 4'hB
`define LBD_FACTOR_DEFAULT 4'hA

// output swing codes
`define LBD_SWING_LOW 2'h0
`define LBD_SWING_MED 2'h1
`define LBD_SWING_HIGH 2'h2
`define LBD_SWING_DEFAULT 2'h1

// pre-emphasis: 0 enables boost
`define LBD_PREEMPH_DEFAULT 1'h0

// register map (byte addresses)
`define LBD_REG_CTRL 12'h000
`define LBD_REG_TXCFG 12'h004
`define LBD_REG_STATUS 12'h008
`define LBD_REG_RXDATA 12'h00C
`define LBD_REG_TXDATA 12'h010

// ctrl field positions
`define LBD_CTRL_FACTOR_LSB 0
`define LBD_CTRL_ROLL_LSB 4
`define LBD_CTRL_RXMODE_LSB 8
`define LBD_CTRL_TXMODE_LSB 10
`define LBD_CTRL_LOOP_BIT 12
`define LBD_CTRL_SLIP_BIT 13
`define LBD_CTRL_RESET 32'h0000_00BA

// txcfg field positions
`define LBD_TXCFG_SWING_LSB 0
`define LBD_TXCFG_PREEMPH_BIT 2
`define LBD_TXCFG_RESET 32'h0000_0001

// bit-slip data latency in parallel cycles
`define LBD_SLIP_LATENCY 2

`endif

// *** rtl/lbd_pkg.sv ***
package lbd_pkg;
    // path mode: full serdes, or bypass ddr / sdr
    typedef enum logic [1:0] {
        LBD_MODE_SERDES = 2'h0,
        LBD_MODE_DDR = 2'h1,
        LBD_MODE_SDR = 2'h3
    } lbd_mode_t;

    typedef enum logic [1:0] {
        LBD_BUS_IDLE = 2'h0,
        LBD_BUS_DATA = 2'h1
    } lbd_bus_t;
endpackage : lbd_pkg

// *** rtl/lbd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser
module lbd_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // async in, synced out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : lbd_sync

`default_nettype wire

// *** rtl/lbd_rx_bitslip.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defines.svh"

// Behaviour
// - transmit serializer bypass gives factor 2 in DDR and 1 in SDR.
// - two output registers, each usable in DDR or SDR mode.
// - DDR bypass registers output on io clock; SDR passes data straight through.
// - transmit bypass width is 1 bit SDR, 2 bits DDR.
// - swing code 00 low, 01 medium default, 10 high.
// - pre-emphasis bit 0 enables boost and is default, 1 disables.
// - deserializer uses shift and load registers, word up to 10 bits.
// - deserialization factor is static, 4 through 10.
// - each channel realigns by inserting single bit delays before deserializing.
// - each channel has its own independent bit-slip request input.
// - one bit inserted per rising edge of request; edge triggered.
// - realigned data valid two parallel cycles after slip edge.
// - up to 11 bits insertion; rollover point programmable 1 to 11.
// - rollover flag pulses exactly one parallel clock cycle; here it is high for one clk cycle.
// - two input registers in DDR or SDR allow bypass factors 2, 1.
// - with deserializer bypassed, bit-slip requests have no effect.
// - rx DDR bypass registers on io clock; SDR passes straight; widths 1/2.
// - serial input captured on rising edge of the serial fast clock.
// - loopback only within same pair and true differential standard.
// - loopback drives transmit output from paired input buffer, not core.
// - parallel clocks and load enable derived; load rate follows factor.
module lbd_rx_bitslip
    import lbd_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int WORD_MAX = 10,
    parameter int DELAY_MAX = 11
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link pins
    input wire logic link_clk,
    input wire logic [CHANNELS-1:0] rx_serial,
    output logic [CHANNELS-1:0] tx_serial,
    // static transmit settings to the pad
    output logic [1:0] output_swing_setting,
    output logic preemph_disable,
    output logic true_diff_std,
    // fabric side: per-channel slip, word and rollover, plus the shared load strobe
    input wire logic [CHANNELS-1:0] slip_req,
    output logic [CHANNELS*WORD_MAX-1:0] rx_word,
    output logic [CHANNELS-1:0] rollover,
    output logic par_clk_en
);
    import lbd_pkg::*;

    localparam int DW = $clog2(DELAY_MAX + 1);
    localparam int HIST = WORD_MAX + DELAY_MAX + 1;

    // control registers
    logic [31:0] ctrl;
    logic [31:0] txcfg;
    logic [31:0] txdata;
    wire [3:0] factor = ctrl[`LBD_CTRL_FACTOR_LSB +: 4];
    wire [3:0] roll_pt = ctrl[`LBD_CTRL_ROLL_LSB +: 4];
    wire [1:0] rx_mode = ctrl[`LBD_CTRL_RXMODE_LSB +: 2];
    wire [1:0] tx_mode = ctrl[`LBD_CTRL_TXMODE_LSB +: 2];
    wire loop_en = ctrl[`LBD_CTRL_LOOP_BIT];
    wire soft_slip = ctrl[`LBD_CTRL_SLIP_BIT];

    // link clock and serial data synchronised into clk
    logic link_clk_s;
    logic link_clk_d;
    logic [CHANNELS-1:0] rx_s;
    lbd_sync #(.WIDTH(1)) u_sync_clk (
        .clk(clk),
        .rst_n(rst_n),
        .d(link_clk),
        .q(link_clk_s)
    );
    lbd_sync #(.WIDTH(CHANNELS)) u_sync_rx (
        .clk(clk),
        .rst_n(rst_n),
        .d(rx_serial),
        .q(rx_s)
    );

    // rising and falling edges of the serial fast clock
    wire bit_rise = link_clk_s & ~link_clk_d;
    wire bit_fall = ~link_clk_s & link_clk_d;

    // parallel load enable: one pulse every factor bits
    logic [3:0] bit_cnt;
    wire factor_ok = (factor >= 4'(`LBD_FACTOR_MIN))
        && (factor <= 4'(`LBD_FACTOR_MAX));
    wire [3:0] eff_factor = factor_ok ? factor : `LBD_FACTOR_DEFAULT;
    wire serdes_mode = (rx_mode == LBD_MODE_SERDES);
    wire load_en = bit_rise && (bit_cnt == eff_factor - 4'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_clk_d <= 1'b0;
            bit_cnt <= 4'h0;
            par_clk_en <= 1'b0;
        end else begin
            link_clk_d <= link_clk_s;
            par_clk_en <= load_en;
            if (bit_rise) begin
                bit_cnt <= load_en ? 4'h0 : bit_cnt + 4'h1;
            end
        end
    end

    // rollover point clamped into 1..11
    wire [3:0] roll_eff = (roll_pt < 4'(`LBD_ROLL_MIN)) ? 4'h1 :
        (roll_pt > 4'(`LBD_ROLL_MAX)) ? 4'(`LBD_ROLL_MAX) : roll_pt;

    // request synchroniser for the fabric slip inputs
    logic [CHANNELS-1:0] slip_s;
    lbd_sync #(.WIDTH(CHANNELS)) u_sync_slip (
        .clk(clk),
        .rst_n(rst_n),
        .d(slip_req),
        .q(slip_s)
    );

    // per-channel realignment and deserializer
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_ch
            logic [HIST-1:0] hist;
            logic [DW-1:0] delay;
            logic [WORD_MAX-1:0] shreg;
            logic [WORD_MAX-1:0] word;
            logic req_lvl;
            logic req_d;
            logic pend;
            logic roll_q;
            logic [1:0] ddr_pair;
            // slip requests may come from fabric pin or the control bit
            wire req = slip_s[c] | soft_slip;
            wire req_edge = req & ~req_d;
            // latch edge until the next word boundary, keeps one per edge
            wire apply = pend && load_en && serdes_mode;
            wire wrap = apply && (delay >= DW'(roll_eff));
            // delayed tap picks the serial bit delay positions back
            wire tap = hist[delay];

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    hist <= '0;
                    delay <= '0;
                    shreg <= '0;
                    word <= '0;
                    req_lvl <= 1'b0;
                    req_d <= 1'b0;
                    pend <= 1'b0;
                    roll_q <= 1'b0;
                    ddr_pair <= 2'h0;
                end else begin
                    req_d <= req;
                    roll_q <= 1'b0;
                    if (req_edge && serdes_mode) begin
                        pend <= 1'b1;
                    end else if (apply) begin
                        pend <= 1'b0;
                    end
                    if (apply) begin
                        delay <= wrap ? '0 : delay + DW'(1);
                        roll_q <= wrap;
                    end
                    if (bit_rise) begin
                        hist <= {hist[HIST-2:0], rx_s[c]};
                        shreg <= {shreg[WORD_MAX-2:0], tap};
                    end
                    // ddr bypass: rising then falling capture
                    if (bit_rise) begin
                        ddr_pair[1] <= rx_s[c];
                    end
                    if (bit_fall) begin
                        ddr_pair[0] <= rx_s[c];
                    end
                    unique case (rx_mode)
                        LBD_MODE_SERDES: begin
                            if (load_en) begin
                                word <= shreg;
                            end
                        end
                        LBD_MODE_DDR: begin
                            word <= {{(WORD_MAX-2){1'b0}}, ddr_pair};
                        end
                        default: begin
                            word <= {{(WORD_MAX-1){1'b0}}, rx_s[c]};
                        end
                    endcase
                end
            end
            assign rx_word[c*WORD_MAX +: WORD_MAX] = word;
            assign rollover[c] = roll_q;
        end
    endgenerate

    // transmit bypass: two output registers, ddr or sdr
    logic [CHANNELS-1:0] tx_q;
    logic [1:0] tx_hold;
    wire [1:0] tx_bits = txdata[1:0];
    // loopback only when the pad is a true differential standard
    wire loop_ok = loop_en && true_diff_std;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold <= 2'h0;
            tx_q <= '0;
        end else begin
            if (bit_rise) begin
                tx_hold <= tx_bits;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (loop_ok) begin
                    tx_q[i] <= rx_s[i];
                end else if (tx_mode == LBD_MODE_SDR) begin
                    tx_q[i] <= tx_bits[0];
                end else if (bit_rise) begin
                    tx_q[i] <= tx_hold[1];
                end else if (bit_fall) begin
                    tx_q[i] <= tx_hold[0];
                end
            end
        end
    end
    assign tx_serial = tx_q;

    // ahb-lite slave: zero wait states, always okay
    logic [11:0] addr_q;
    logic wr_q;
    logic act_q;
    wire addr_phase = hsel && hready && htrans[1];
    wire [CHANNELS-1:0] roll_any = rollover;
    logic [31:0] status;
    logic [31:0] next_rdata;

    always_comb begin
        status = 32'h0;
        status[CHANNELS-1:0] = roll_any;
        status[16 +: DW] = g_ch[0].delay;
        next_rdata = 32'h0;
        unique case (haddr)
            `LBD_REG_CTRL: next_rdata = ctrl;
            `LBD_REG_TXCFG: next_rdata = txcfg;
            `LBD_REG_STATUS: next_rdata = status;
            `LBD_REG_RXDATA: next_rdata = 32'(rx_word[WORD_MAX-1:0]);
            `LBD_REG_TXDATA: next_rdata = txdata;
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 12'h0;
            wr_q <= 1'b0;
            act_q <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            act_q <= addr_phase;
            wr_q <= hwrite;
            addr_q <= haddr;
            if (addr_phase && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `LBD_CTRL_RESET;
            txcfg <= `LBD_TXCFG_RESET;
            txdata <= 32'h0;
        end else if (act_q && wr_q) begin
            unique case (addr_q)
                `LBD_REG_CTRL: ctrl <= hwdata;
                `LBD_REG_TXCFG: txcfg <= hwdata;
                `LBD_REG_TXDATA: txdata <= hwdata;
                default: ctrl <= ctrl;
            endcase
        end
    end

    // static pad settings, registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_swing_setting <= `LBD_SWING_DEFAULT;
            preemph_disable <= `LBD_PREEMPH_DEFAULT;
            true_diff_std <= 1'b1;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // code 11 is undefined: hold the default swing
            output_swing_setting <= (txcfg[1:0] == 2'h3) ?
                `LBD_SWING_DEFAULT : txcfg[1:0];
            preemph_disable <= txcfg[`LBD_TXCFG_PREEMPH_BIT];
            true_diff_std <= ~txcfg[3];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : lbd_rx_bitslip

`default_nettype wire

// *** dv/lbd_rx_bitslip_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defines.svh"

module lbd_rx_bitslip_checker #(
    parameter int CHANNELS = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // pad and fabric side
    input wire logic [1:0] output_swing_setting,
    input wire logic preemph_disable,
    input wire logic [CHANNELS-1:0] slip_req,
    input wire logic [CHANNELS-1:0] rollover,
    input wire logic par_clk_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic [8:0] since_slip;
    assign take = hsel && hready && htrans[1];
    // saturates so a long quiet spell never wraps back into range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) since_slip <= 9'h1FF;
        else if ($rose(slip_req[0])) since_slip <= 9'h000;
        else if (since_slip != 9'h1FF) since_slip <= since_slip + 9'h001;
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state seen");
    a_roll_pulse: assert property (
        rollover[0] |=> !rollover[0]) else $error("lane 0 flag too long");
    a_roll_pulse_one: assert property (
        rollover[1] |=> !rollover[1]) else $error("lane 1 flag too long");
    a_swing_legal: assert property (
        output_swing_setting != 2'h3) else $error("swing code illegal");
    a_load_pulse: assert property (
        par_clk_en |=> !par_clk_en) else $error("load strobe too long");
    a_roll_cause: assert property (
        rollover[0] |-> since_slip < 9'h0C8)
        else $error("wrap without a request edge");
    a_pad_write: assert property (
        (take && hwrite && haddr == `LBD_REG_TXCFG)
        ##1 (hwdata[1:0] != 2'h3) |-> ##2
        {preemph_disable, output_swing_setting} == $past(hwdata[2:0], 2))
        else $error("pad setting not applied");
endmodule : lbd_rx_bitslip_checker

bind lbd_rx_bitslip lbd_rx_bitslip_checker #(.CHANNELS(CHANNELS)) u_chk (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp),
    .output_swing_setting(output_swing_setting),
    .preemph_disable(preemph_disable), .slip_req(slip_req),
    .rollover(rollover), .par_clk_en(par_clk_en)
);
`default_nettype wire

// *** dv/lbd_link_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// far-end sender: both lanes carry the same 4-bit pattern, oldest bit first
module lbd_link_src (
    // frame control
    input wire logic run,
    // link pins
    output logic link_clk,
    output logic [1:0] rx_serial
);
    logic [3:0] pat = 4'h8;
    int idx = 0;
    initial begin
        link_clk = 1'b0;
        rx_serial = 2'h1;
        #3;
        forever begin
            #32;
            if (run) begin
                link_clk = ~link_clk;
                // launch on the fall so the rising edge sees settled data
                if (!link_clk) begin
                    rx_serial = {2{pat[3 - idx]}};
                    idx = (idx + 1) % 4;
                end
            end else begin
                // outside frames the lanes hold nothing useful
                rx_serial = ~rx_serial;
            end
        end
    end
endmodule : lbd_link_src
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defines.svh"

module tb_top;
    logic clk, rst_n, hsel, hwrite, run, hreadyout, par_clk_en, preemph;
    logic link_clk;
    logic [11:0] haddr;
    logic [1:0] htrans, slip_req, rollover, rx_serial, swing;
    logic [31:0] hwdata, hrdata;
    logic [19:0] rx_word;
    logic [1:0] tx_serial;
    logic true_diff;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rolls = 0;
    int rolls1 = 0;

    lbd_rx_bitslip u_dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .link_clk(link_clk), .rx_serial(rx_serial),
        .tx_serial(tx_serial), .output_swing_setting(swing),
        .preemph_disable(preemph), .true_diff_std(true_diff),
        .slip_req(slip_req),
        .rx_word(rx_word), .rollover(rollover), .par_clk_en(par_clk_en)
    );
    lbd_link_src u_src (.run(run), .link_clk(link_clk), .rx_serial(rx_serial));

    always #2.5 clk = ~clk;
    always @(posedge clk) if (rollover[0] === 1'b1) rolls++;
    always @(posedge clk) if (rollover[1] === 1'b1) rolls1++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // hsel stays up; idle htrans marks the gaps, so no pin toggles twice
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wait_loads(input int n);
        repeat (n) begin
            do @(posedge clk); while (par_clk_en !== 1'b1);
        end
    endtask : wait_loads

    task automatic t_regs();
        logic [31:0] d;
        bus(`LBD_REG_CTRL, 1'b0, 32'h0, d);
        check(d, `LBD_CTRL_RESET);
        bus(`LBD_REG_TXCFG, 1'b0, 32'h0, d);
        check(d, `LBD_TXCFG_RESET);
        check(32'(swing), 32'(`LBD_SWING_DEFAULT));
        check(32'(preemph), 32'(`LBD_PREEMPH_DEFAULT));
        for (int c = 0; c < 3; c++) begin
            bus(`LBD_REG_TXCFG, 1'b1, 32'(c + 4 * (c % 2)), d);
            bus(12'h0F0, 1'b0, 32'h0, d);
            check(32'(swing), 32'(c));
            check(32'(preemph), 32'(c % 2));
        end
        check(d, 32'h0);
    endtask : t_regs

    // period-4 pattern: each slip rotates the word right, the wrap leaves it unchanged
    task automatic t_slip();
        logic [31:0] d;
        logic [3:0] w, w1;
        int r;
        bus(`LBD_REG_CTRL, 1'b1, 32'h0000_0044, d);
        run <= 1'b1;
        wait_loads(6);
        w = rx_word[3:0];
        w1 = rx_word[13:10];
        for (int k = 1; k <= 5; k++) begin
            r = rolls;
            slip_req[0] <= 1'b1;
            wait_loads(2);
            slip_req[0] <= 1'b0;
            wait_loads(4);
            if (k < 5) w = {w[0], w[3:1]};
            check(32'(rx_word[3:0]), 32'(w));
            check(32'(rolls - r), 32'(k == 5));
        end
        check(32'(rx_word[13:10]), 32'(w1));
        check(32'(rolls1), 32'h0);
    endtask : t_slip

    // load strobe rate is not defined in bypass, so pace by clocks instead
    task automatic t_bypass();
        logic [31:0] d, s0;
        int r;
        bus(`LBD_REG_CTRL, 1'b1, 32'h0000_0344, d);
        bus(`LBD_REG_STATUS, 1'b0, 32'h0, s0);
        r = rolls;
        repeat (6) begin
            slip_req[0] <= 1'b1;
            repeat (120) @(posedge clk);
            slip_req[0] <= 1'b0;
            repeat (120) @(posedge clk);
        end
        bus(`LBD_REG_STATUS, 1'b0, 32'h0, d);
        check(32'(d[19:16]), 32'(s0[19:16]));
        check(32'(rolls - r), 32'h0);
    endtask : t_bypass

    // loopback echoes the lanes; a non-true standard falls back to sdr data
    task automatic t_loop();
        logic [31:0] d;
        bus(`LBD_REG_TXDATA, 1'b1, 32'h0000_0001, d);
        bus(`LBD_REG_CTRL, 1'b1, 32'h0000_1C44, d);
        repeat (2) begin
            // sample well after the rise, once the 3-flop echo has settled
            @(posedge link_clk);
            repeat (5) @(posedge clk);
            check(32'(tx_serial), 32'(rx_serial));
        end
        bus(`LBD_REG_TXCFG, 1'b1, 32'h0000_0009, d);
        repeat (4) @(posedge clk);
        check(32'(true_diff), 32'h0);
        check(32'(tx_serial), 32'h3);
    endtask : t_loop

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b1;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        run = 1'b0;
        slip_req = 2'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_slip();
        t_bypass();
        t_loop();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
